// ### include/driver_fault_params.svh
// Purpose: Constants for the half-bridge driver fault supervisor.
// Assumes: 16-bit serial frames, core clock of 25 MHz.
// Notes:   Bit positions, reset values and timing figures in one place.
`ifndef DRIVER_FAULT_PARAMS_SVH
`define DRIVER_FAULT_PARAMS_SVH

`define CORE_CLK_MHZ        25
`define OC_SHORT_US         25
`define OC_LONG_US          200
`define UL_DELAY_US         350

`define CHANNELS            6
`define DRIVERS             12
`define FRAME_BITS          5'h10
`define FRAME_W             16
`define BITCNT_W            5
`define TIMER_W             14
`define PIN_W               41

`define IN_OV_EN_BIT        15
`define IN_UL_EN_BIT        14
`define IN_OC_SEL_BIT       13
`define IN_CMD_MSB          12
`define IN_CMD_LSB          1
`define IN_STATUS_CLR_BIT   0

`define OUT_SUPPLY_FAIL_BIT 15
`define OUT_ULF_BIT         14
`define OUT_OCF_BIT         13
`define OUT_TWF_BIT         0

`define CMD_RESET           12'h000
`define OV_EN_RESET         1'h1
`define UL_EN_RESET         1'h0
`define OC_SEL_RESET        1'h0

`endif

// ### include/driver_fault_pkg.sv
// Purpose: Types for the driver fault supervisor.
// Assumes: Constants come from driver_fault_params.svh.
// Notes:   Each module keeps all of its state except the reset synchroniser in one of these structs.
`include "driver_fault_params.svh"

package driver_fault_pkg;

    typedef struct packed {
        logic                     running;
        logic                     sel_short;
        logic                     fired;
        logic [`TIMER_W-1:0]      cnt;
    } timer_state_t;

    typedef struct packed {
        logic [`PIN_W-1:0]        pin_meta;
        logic [`PIN_W-1:0]        pin_sync;
        logic                     cs_d;
        logic                     sclk_d;
        logic [`FRAME_W-1:0]      rx_shift;
        logic [`BITCNT_W-1:0]     bit_cnt;
        logic [`FRAME_W-1:0]      tx_shift;
        logic                     quick_read;
        logic [`DRIVERS-1:0]      cmd;
        logic                     ov_en;
        logic                     ul_en;
        logic                     oc_sel;
        logic                     supply_fail;
        logic                     twf;
        logic                     ocf;
        logic                     ulf;
        logic [`DRIVERS-1:0]      oc_off;
        logic [`DRIVERS-1:0]      ul_off;
        logic [`TIMER_W-1:0]      ul_cnt;
        logic [`DRIVERS-1:0]      drive;
        logic                     so;
        logic                     so_oe;
    } sup_state_t;

endpackage : driver_fault_pkg

// ### core/fault_delay_timer.sv
// Purpose: Overcurrent latch-off delay for one driver.
// Assumes: cond_in is already synchronised to core_clk_in.
// Notes:   The delay length is frozen when the condition first appears.
`timescale 1ns/1ps
`default_nettype none

`include "driver_fault_params.svh"

module fault_delay_timer
    import driver_fault_pkg::*;
#(
    parameter int CNT_W        = 14,
    parameter int SHORT_CYCLES = 625,
    parameter int LONG_CYCLES  = 5000
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic cond_in,
    input  wire logic sel_short_in,
    output logic      expired_out
);

    localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_CYCLES - 1);
    localparam logic [CNT_W-1:0] LONG_LAST  = CNT_W'(LONG_CYCLES - 1);

    timer_state_t st_reg;
    timer_state_t st_next;
    logic [CNT_W-1:0] last;

    always_comb begin
        st_next = st_reg;
        last    = st_reg.sel_short ? SHORT_LAST : LONG_LAST;
        if (!cond_in) begin
            st_next.running = 1'h0;
            st_next.fired   = 1'h0;
            st_next.cnt     = '0;
        end else if (!st_reg.running) begin
            st_next.running   = 1'h1;
            st_next.sel_short = sel_short_in; // see RULE_18
            st_next.cnt       = '0;
        end else if (st_reg.cnt[CNT_W-1:0] == last) begin
            st_next.fired = 1'h1;
        end else begin
            st_next.cnt = st_reg.cnt + `TIMER_W'(1); // see RULE_15
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired_out = st_reg.fired;

    a_delay_frozen: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE_18
        st_reg.running && cond_in |=> $stable(st_reg.sel_short))
        else $error("running delay changed its length select");

    a_short_fire: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see RULE_15
        $rose(st_reg.fired) |-> $past(st_reg.cnt) == last)
        else $error("overcurrent delay fired at the wrong count");

endmodule : fault_delay_timer

`default_nettype wire

// ### core/driver_fault_supervisor.sv
// Purpose: Fault supervision and serial status for a six-channel half-bridge driver.
// Assumes: Serial pins and fault comparators are asynchronous to core_clk_in.
// Notes:   All pin inputs pass two flops; readout lags chip select by about three cycles.
`timescale 1ns/1ps
`default_nettype none

`include "driver_fault_params.svh"

// Function
// RULE_01 - Overvoltage on either rail sets supply fail
// RULE_02 - Overvoltage with shutdown enabled forces outputs off
// RULE_03 - Keep commands, restore outputs after supply recovers
// RULE_04 - Shutdown disabled: flag only, outputs unchanged
// RULE_05 - Supply fail sticky until status reset
// RULE_06 - Six sensors, warning and shutdown levels
// RULE_07 - Warning sets flag, outputs stay on
// RULE_08 - Any shutdown level turns all off together
// RULE_09 - Thermal shutdown keeps commands, resumes automatically
// RULE_10 - Thermal warning sticky until status reset
// RULE_11 - Select fall with input low shows warning
// RULE_12 - Readout is 0 without, 1 with warning
// RULE_13 - Readout valid before any serial clock edge
// RULE_14 - Host never enables both switches of leg
// RULE_15 - Overcurrent latches driver off after 25/200 us
// RULE_16 - Underload latches off after 350 us if enabled
// RULE_17 - Only valid frame with reset request clears latches
// RULE_18 - Running overcurrent delay ignores select changes
// RULE_19 - Invalid frame leaves latched flags unchanged
module driver_fault_supervisor
    import driver_fault_pkg::*;
#(
    parameter int OC_SHORT_CYCLES = `OC_SHORT_US * `CORE_CLK_MHZ,
    parameter int OC_LONG_CYCLES  = `OC_LONG_US * `CORE_CLK_MHZ,
    parameter int UL_CYCLES       = `UL_DELAY_US * `CORE_CLK_MHZ
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 chip_select_n_in,
    input  wire logic                 serial_clk_in,
    input  wire logic                 serial_data_in,
    input  wire logic [1:0]           supply_rail_ov_in,
    input  wire logic [`CHANNELS-1:0] thermal_warn_in,
    input  wire logic [`CHANNELS-1:0] thermal_shutdown_in,
    input  wire logic [`DRIVERS-1:0]  overcurrent_in,
    input  wire logic [`DRIVERS-1:0]  underload_in,
    output logic [`DRIVERS-1:0]       driver_output_out,
    output logic                      serial_data_out,
    output logic                      serial_data_oe_out,
    output logic                      supply_fail_flag_out,
    output logic                      thermal_warning_flag_out,
    output logic                      overload_flag_out,
    output logic                      underload_flag_out
);

    localparam logic [`TIMER_W-1:0] UL_LAST = `TIMER_W'(UL_CYCLES - 1);

    logic [1:0]               rst_pipe;
    logic                     rst_n;
    sup_state_t               st_reg;
    sup_state_t               st_next;
    logic                     cs_s;
    logic                     sclk_s;
    logic                     si_s;
    logic [1:0]               ov_s;
    logic [`CHANNELS-1:0]     warn_s;
    logic [`CHANNELS-1:0]     tsd_s;
    logic [`DRIVERS-1:0]      oc_s;
    logic [`DRIVERS-1:0]      ul_s;
    logic [`DRIVERS-1:0]      oc_fired;
    logic                     ov_any;
    logic                     tsd_any;
    logic                     cs_fall;
    logic                     cs_rise;
    logic                     sclk_rise;
    logic                     sclk_fall;
    logic                     frame_ok;
    logic                     frame_bad;
    logic                     clear_req;
    logic                     ul_fire;
    logic [`DRIVERS-1:0]      ul_hit;

    // Reset is released through two flops so every flop leaves reset on one edge
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    assign {ul_s, oc_s, tsd_s, warn_s, ov_s, si_s, sclk_s, cs_s} = st_reg.pin_sync;

    assign ov_any    = |ov_s;                                        // see RULE_01
    assign tsd_any   = |tsd_s;                                       // see RULE_06
    assign cs_fall   = st_reg.cs_d && !cs_s;
    assign cs_rise   = !st_reg.cs_d && cs_s;
    assign sclk_rise = !cs_s && !st_reg.sclk_d && sclk_s;
    assign sclk_fall = !cs_s && st_reg.sclk_d && !sclk_s;
    // A frame counts only with exactly sixteen clocks between select edges
    assign frame_ok  = cs_rise && (st_reg.bit_cnt == `FRAME_BITS);   // see RULE_19
    assign frame_bad = cs_rise && !frame_ok;
    assign clear_req = frame_ok && st_reg.rx_shift[`IN_STATUS_CLR_BIT]; // see RULE_17
    assign ul_hit    = ul_s & st_reg.drive;
    assign ul_fire   = (|ul_hit) && (st_reg.ul_cnt == UL_LAST);      // see RULE_16

    genvar g;
    generate
        for (g = 0; g < `DRIVERS; g++) begin : gen_oc
            fault_delay_timer #(
                .CNT_W        (`TIMER_W),
                .SHORT_CYCLES (OC_SHORT_CYCLES),
                .LONG_CYCLES  (OC_LONG_CYCLES)
            ) u_oc_timer (
                .clk_in       (core_clk_in),
                .rst_n_in     (rst_n),
                .cond_in      (oc_s[g] && st_reg.drive[g]),
                .sel_short_in (st_reg.oc_sel),
                .expired_out  (oc_fired[g])
            );
        end
    endgenerate

    always_comb begin
        st_next          = st_reg;
        st_next.pin_meta = {underload_in, overcurrent_in, thermal_shutdown_in, thermal_warn_in,
                            supply_rail_ov_in, serial_data_in, serial_clk_in, chip_select_n_in};
        st_next.pin_sync = st_reg.pin_meta;
        st_next.cs_d     = cs_s;
        st_next.sclk_d   = sclk_s;

        // Serial receive and transmit
        if (cs_fall) begin
            st_next.bit_cnt    = '0;
            st_next.quick_read = !si_s;                              // see RULE_11
            st_next.tx_shift   = {st_reg.supply_fail, st_reg.ulf, st_reg.ocf,
                                  st_reg.oc_off | st_reg.ul_off, st_reg.twf};
        end else if (sclk_rise) begin
            st_next.rx_shift   = {st_reg.rx_shift[`FRAME_W-2:0], si_s};
            st_next.quick_read = 1'h0;
            if (st_reg.bit_cnt <= `FRAME_BITS) begin
                st_next.bit_cnt = st_reg.bit_cnt + `BITCNT_W'(1);
            end
        end else if (sclk_fall) begin
            st_next.tx_shift = {st_reg.tx_shift[`FRAME_W-2:0], 1'h0};
        end

        if (frame_ok) begin
            st_next.ov_en  = st_reg.rx_shift[`IN_OV_EN_BIT];
            st_next.ul_en  = st_reg.rx_shift[`IN_UL_EN_BIT];
            st_next.oc_sel = st_reg.rx_shift[`IN_OC_SEL_BIT];
            st_next.cmd    = st_reg.rx_shift[`IN_CMD_MSB:`IN_CMD_LSB];
        end

        // Clearing first, setting after, so a fresh event always survives
        if (clear_req) begin
            st_next.supply_fail = 1'h0;                              // see RULE_05
            st_next.twf    = 1'h0;                                   // see RULE_10
            st_next.ocf    = 1'h0;
            st_next.ulf    = 1'h0;
            st_next.oc_off = '0;                                     // see RULE_17
            st_next.ul_off = '0;
        end
        if (ov_any) begin
            st_next.supply_fail = 1'h1;                              // see RULE_01
        end
        if (|warn_s) begin
            st_next.twf = 1'h1;                                      // see RULE_07
        end
        if (|oc_fired) begin
            st_next.ocf    = 1'h1;
            st_next.oc_off = st_next.oc_off | oc_fired;              // see RULE_15
        end

        // One shared underload timer; later channels get what is left of it
        if (!(|ul_hit)) begin
            st_next.ul_cnt = '0;
        end else if (!ul_fire) begin
            st_next.ul_cnt = st_reg.ul_cnt + `TIMER_W'(1);
        end
        if (ul_fire) begin
            st_next.ulf = 1'h1;
            if (st_reg.ul_en) begin
                st_next.ul_off = st_next.ul_off | ul_hit;            // see RULE_16
            end
        end

        // Commands are never touched by faults, so recovery from overvoltage and thermal shutdown needs no host action
        st_next.drive = st_next.cmd & ~st_next.oc_off & ~st_next.ul_off
                      & {`DRIVERS{!(ov_any && st_reg.ov_en)}}        // see RULE_02
                      & {`DRIVERS{!tsd_any}};                        // see RULE_08 RULE_09

        st_next.so_oe = !cs_s;
        st_next.so    = st_next.quick_read ? st_next.twf : st_next.tx_shift[`FRAME_W-1]; // see RULE_12
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_reg          <= '0;
            st_reg.pin_meta <= {`PIN_W{1'h0}} | `PIN_W'(3);
            st_reg.pin_sync <= {`PIN_W{1'h0}} | `PIN_W'(3);
            st_reg.cs_d     <= 1'h1;
            st_reg.sclk_d   <= 1'h1;
            st_reg.cmd      <= `CMD_RESET;
            st_reg.ov_en    <= `OV_EN_RESET;
            st_reg.ul_en    <= `UL_EN_RESET;
            st_reg.oc_sel   <= `OC_SEL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign driver_output_out        = st_reg.drive;
    assign serial_data_out          = st_reg.so;                     // see RULE_13
    assign serial_data_oe_out       = st_reg.so_oe;
    assign supply_fail_flag_out     = st_reg.supply_fail;
    assign thermal_warning_flag_out = st_reg.twf;
    assign overload_flag_out        = st_reg.ocf;
    assign underload_flag_out       = st_reg.ulf;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    a_supply_fail_set: assert property (ov_any |=> st_reg.supply_fail) // see RULE_01
        else $error("overvoltage did not set supply fail");

    a_ov_shutdown: assert property (ov_any && st_reg.ov_en |=> st_reg.drive == '0) // see RULE_02
        else $error("outputs on during enabled overvoltage");

    a_ov_ignored: assert property (ov_any && !st_reg.ov_en && !tsd_any && !frame_ok // see RULE_04
        && st_next.oc_off == '0 && st_next.ul_off == '0 |=> st_reg.drive == $past(st_reg.cmd))
        else $error("outputs changed with overvoltage shutdown disabled");

    a_cmd_kept: assert property ((ov_any || tsd_any) && !frame_ok |=> $stable(st_reg.cmd)) // see RULE_03
        else $error("fault altered stored commands");

    a_fail_sticky: assert property (st_reg.supply_fail && !clear_req |=> st_reg.supply_fail) // see RULE_05
        else $error("supply fail cleared without reset request");

    a_warn_sticky: assert property (st_reg.twf && !clear_req |=> st_reg.twf) // see RULE_10
        else $error("thermal warning cleared without reset request");

    a_tsd_off: assert property (tsd_any |=> st_reg.drive == '0) // see RULE_08
        else $error("outputs on during thermal shutdown");

    a_warn_set: assert property ((|warn_s) |=> st_reg.twf) // see RULE_07
        else $error("thermal warning flag not set");

    // The readout follows the live flag, so a warning arriving mid-readout shows at once
    a_quick_read: assert property (cs_fall && !si_s ##1 !sclk_rise |=> // see RULE_11
        serial_data_out == st_reg.twf && serial_data_oe_out)
        else $error("quick readout does not show thermal warning");

    a_bad_frame: assert property (frame_bad |=> $stable(st_reg.cmd) && // see RULE_19
        (st_reg.supply_fail || !$past(st_reg.supply_fail)) &&
        (st_reg.ocf || !$past(st_reg.ocf)) && (st_reg.twf || !$past(st_reg.twf)))
        else $error("invalid frame changed latched state");

    a_ul_disabled: assert property (ul_fire && !st_reg.ul_en && !clear_req |=> // see RULE_16
        st_reg.ul_off == $past(st_reg.ul_off) && st_reg.ulf)
        else $error("underload latched a driver while disabled");

    a_oc_latch: assert property (|oc_fired |=> st_reg.ocf && (st_reg.drive & $past(oc_fired)) == '0) // see RULE_15
        else $error("overcurrent did not latch the driver off");

endmodule : driver_fault_supervisor

`default_nettype wire

// ### sim/spi_host_model.sv
// Purpose: Serial host model that frames accesses to the fault supervisor.
// Assumes: Link clock of 320 ns period, idle low, stopped between frames.
// Notes:   Data out is inverted on release so a stale level never looks valid.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    output logic      chip_select_n_out,
    output logic      serial_clk_out,
    output logic      serial_data_out,
    input  wire logic serial_data_in,
    input  wire logic serial_data_oe_in
);
    localparam int HALF = 160;

    initial begin
        chip_select_n_out = 1'b1;
        serial_clk_out    = 1'b0;
        serial_data_out   = 1'b1;
    end

    // Rises other than 16 give an invalid frame on purpose
    task automatic frame(input logic [15:0] word, input int rises,
                         output logic [15:0] rx);
        rx = 16'h0000;
        serial_data_out = word[15];
        #(HALF);
        chip_select_n_out = 1'b0;
        #(3*HALF);
        for (int k = 0; k < rises; k++) begin
            serial_data_out = word[15-k];
            #(HALF);
            serial_clk_out = 1'b1;
            #(HALF-10);
            rx[15-k] = serial_data_oe_in ? serial_data_in : 1'bx;
            #10;
            serial_clk_out = 1'b0;
        end
        #(HALF);
        chip_select_n_out = 1'b1;
        serial_data_out = ~serial_data_out;
        #(3*HALF);
    endtask : frame

    // Select falls with data low and no clock edge at all
    task automatic quick(output logic bit_out);
        serial_data_out = 1'b0;
        #(HALF);
        chip_select_n_out = 1'b0;
        #(3*HALF);
        bit_out = serial_data_oe_in ? serial_data_in : 1'bx;
        chip_select_n_out = 1'b1;
        serial_data_out = 1'b1;
        #(3*HALF);
    endtask : quick
endmodule : spi_host_model

`default_nettype wire

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the driver fault supervisor.
// Assumes: Shortened delays 10, 400 and 60 cycles via parameters.
// Notes:   Fault pins change on the falling core clock edge.
`timescale 1ns/1ps
`default_nettype none

`include "driver_fault_params.svh"

module tb_top;
    // Bits 2k+1 and 2k form one leg; at most one of each pair is on
    localparam logic [11:0] CMD = 12'hA5A;
    logic        core_clk = 1'b0;
    logic        rstn     = 1'b0;
    wire         cs_n;
    wire         sclk;
    wire         sdi;
    logic [1:0]  rail  = 2'h0;
    logic [5:0]  twarn = 6'h00;
    logic [5:0]  tsd   = 6'h00;
    logic [11:0] oc    = 12'h000;
    logic [11:0] ul    = 12'h000;
    logic [11:0] drv;
    logic        sdo;
    logic        oe;
    logic        supply_fail;
    logic        twf;
    logic        ocf;
    logic        ulf;
    logic [15:0] rx;
    logic        q;
    int          fails       = 0;
    int          comparisons = 0;

    always #20 core_clk = ~core_clk;

    driver_fault_supervisor #(
        .OC_SHORT_CYCLES(10),
        .OC_LONG_CYCLES (400),
        .UL_CYCLES      (60)
    ) DUT (
        .core_clk_in             (core_clk),
        .rstn_in                 (rstn),
        .chip_select_n_in        (cs_n),
        .serial_clk_in           (sclk),
        .serial_data_in          (sdi),
        .supply_rail_ov_in       (rail),
        .thermal_warn_in         (twarn),
        .thermal_shutdown_in     (tsd),
        .overcurrent_in          (oc),
        .underload_in            (ul),
        .driver_output_out       (drv),
        .serial_data_out         (sdo),
        .serial_data_oe_out      (oe),
        .supply_fail_flag_out    (supply_fail),
        .thermal_warning_flag_out(twf),
        .overload_flag_out       (ocf),
        .underload_flag_out      (ulf)
    );

    spi_host_model HOST (
        .chip_select_n_out(cs_n),
        .serial_clk_out   (sclk),
        .serial_data_out  (sdi),
        .serial_data_in   (sdo),
        .serial_data_oe_in(oe)
    );

    function automatic logic [15:0] w(logic ov, logic ue, logic sel, logic clr);
        return {ov, ue, sel, CMD, clr};
    endfunction : w

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic send(input logic [15:0] word, input int rises = 16);
        HOST.frame(word, rises, rx);
        cyc(2);
    endtask : send

    task automatic close_out;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // Whole run is near 110 us; the limit leaves wide margin
    initial begin
        #500us;
        fails++;
        close_out();
    end

    initial begin
        cyc(20);
        rstn = 1'b1;
        cyc(10);
        chk({10'h000, oe, drv[0], supply_fail, ulf, ocf, twf}, 16'h0000);
        send(w(1, 0, 0, 0));
        chk({4'h0, drv}, {4'h0, CMD});
        chk(rx, 16'h0000);
        for (int r = 1; r < 4; r++) begin
            rail = r[1:0];
            cyc(5);
            chk({4'h0, drv}, 16'h0000);
            chk({15'h0000, supply_fail}, 16'h0001);
            rail = 2'h0;
            cyc(5);
            chk({4'h0, drv}, {4'h0, CMD});
            chk({15'h0000, supply_fail}, 16'h0001);
            send(w(1, 0, 0, 1));
            chk(rx, 16'h8000);
            chk({15'h0000, supply_fail}, 16'h0000);
        end
        send(w(0, 0, 0, 0));
        rail = 2'h3;
        cyc(5);
        chk({4'h0, drv}, {4'h0, CMD});
        chk({15'h0000, supply_fail}, 16'h0001);
        rail = 2'h0;
        send(w(1, 0, 0, 1));
        for (int s = 0; s < 6; s++) begin
            twarn = 6'h01 << s;
            cyc(5);
            chk({15'h0000, twf}, 16'h0001);
            chk({4'h0, drv}, {4'h0, CMD});
            twarn = 6'h00;
            tsd = 6'h01 << s;
            cyc(5);
            chk({4'h0, drv}, 16'h0000);
            tsd = 6'h00;
            cyc(5);
            chk({4'h0, drv}, {4'h0, CMD});
        end
        HOST.quick(q);
        chk({15'h0000, q}, 16'h0001);
        chk({15'h0000, twf}, 16'h0001);
        send(w(1, 0, 0, 1), 15);
        chk({15'h0000, twf}, 16'h0001);
        send(w(1, 0, 0, 1));
        chk({15'h0000, twf}, 16'h0000);
        HOST.quick(q);
        chk({15'h0000, q}, 16'h0000);
        oc = 12'h002;
        send(w(1, 0, 1, 0));
        cyc(30);
        chk({4'h0, drv}, {4'h0, CMD});
        cyc(230);
        chk({4'h0, drv}, {4'h0, CMD & 12'hFFD});
        oc = 12'h000;
        send(w(1, 0, 1, 1));
        chk(rx, 16'h2004);
        chk({4'h0, drv}, {4'h0, CMD});
        oc = 12'h008;
        cyc(8);
        chk({4'h0, drv}, {4'h0, CMD});
        cyc(10);
        chk({4'h0, drv}, {4'h0, CMD & 12'hFF7});
        chk({15'h0000, ocf}, 16'h0001);
        oc = 12'h000;
        send(w(1, 0, 1, 1));
        chk({15'h0000, ocf}, 16'h0000);
        ul = 12'h010;
        cyc(75);
        chk({15'h0000, ulf}, 16'h0001);
        chk({4'h0, drv}, {4'h0, CMD});
        ul = 12'h000;
        send(w(1, 1, 1, 1));
        chk({15'h0000, ulf}, 16'h0000);
        ul = 12'h010;
        cyc(50);
        chk({4'h0, drv}, {4'h0, CMD});
        cyc(25);
        chk({4'h0, drv}, {4'h0, CMD & 12'hFEF});
        ul = 12'h000;
        send(w(1, 1, 1, 1));
        chk({4'h0, drv}, {4'h0, CMD});
        close_out();
    end
endmodule : tb_top

`default_nettype wire
